/* design/dvs_pkg.sv */
// constants, field layout and types shared by the dimmer channel files
package dvs_pkg;

    // register word indices on the plain register port
    localparam logic [3:0] A_CTRL  = 4'h0;
    localparam logic [3:0] A_RLIM  = 4'h1;
    localparam logic [3:0] A_ALIM  = 4'h2;
    localparam logic [3:0] A_CLIM  = 4'h3;
    localparam logic [3:0] A_SVAL  = 4'h4;
    localparam logic [3:0] A_OVAL  = 4'h5;
    localparam logic [3:0] A_DLY   = 4'h6;
    localparam logic [3:0] A_RFADE = 4'h7;
    localparam logic [3:0] A_AFADE = 4'h8;
    localparam logic [3:0] A_CFADE = 4'h9;
    localparam logic [3:0] A_SFADE = 4'ha;
    localparam logic [3:0] A_OFADE = 4'hb;
    localparam logic [3:0] A_STAT  = 4'hc;
    localparam logic [3:0] NCFG    = 4'hc;

    // control word field positions
    localparam int C_STAIR  = 0;
    localparam int C_ZOFF   = 1;
    localparam int C_RGB    = 2;
    localparam int C_HOLD   = 5;
    localparam int C_RETRIG = 6;
    localparam int C_OFFR   = 7;
    localparam int C_ORI    = 10;

    // values after reset
    localparam logic [31:0] LIM_RST   = 32'h0000ff00;
    localparam logic [31:0] DLY_RST   = 32'h0000003c;
    localparam logic [31:0] FADE_RST  = 32'h03e803e8;
    localparam logic [31:0] SVAL_RST  = 32'h0000ccff;
    localparam logic [31:0] OVAL_RST  = 32'h0000001a;
    localparam logic [NCFG-1:0][31:0] CFG_RST = {
        FADE_RST, FADE_RST, FADE_RST, FADE_RST, FADE_RST, DLY_RST,
        OVAL_RST, SVAL_RST, LIM_RST, LIM_RST, LIM_RST, 32'h00000000};

    // timing: one fade tick is one millisecond
    localparam int CLK_MHZ  = 250;
    localparam int TICK_US  = 1000;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int PRE_W    = 24;
    localparam logic [9:0] MS_PER_S = 10'h3e8;
    localparam logic [7:0] FULL     = 8'hff;

    // orientation duration codes at the ends of the range
    localparam logic [3:0] ORI_DIS = 4'h0;
    localparam logic [3:0] ORI_UNL = 4'he;

    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,
        ST_ON     = 2'b01,
        ST_DELAY  = 2'b10,
        ST_ORIENT = 2'b11
    } dvs_stair_t;

    typedef enum logic [2:0] {
        OFR_IGNORE = 3'b000,
        OFR_SWOFF  = 3'b001,
        OFR_DELAY  = 3'b010,
        OFR_ORIENT = 3'b011,
        OFR_TWOSTP = 3'b100
    } dvs_offr_t;

    typedef enum logic [2:0] {
        COL_RED   = 3'b000,
        COL_GREEN = 3'b001,
        COL_BLUE  = 3'b010,
        COL_WHITE = 3'b011,
        COL_BRIGHT = 3'b100
    } dvs_col_t;

endpackage : dvs_pkg

/* design/dvs_ramp.sv */
// linear brightness ramp with full-range fade time
`timescale 1ns/1ns
module dvs_ramp (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // millisecond tick
    input  wire logic        tick,
    // new target
    input  wire logic        ld,
    input  wire logic [7:0]  tgt,
    input  wire logic [15:0] fade,
    // brightness
    output logic      [7:0]  level,
    output logic             chan_on
);

    typedef struct packed {
        logic [7:0]  level;
        logic        on;
        logic [7:0]  tgt;
        logic [15:0] fade;
        logic [16:0] acc;
    } dvs_ramp_st_t;

    localparam logic [7:0] FULL_W = dvs_pkg::FULL;

    dvs_ramp_st_t s;
    dvs_ramp_st_t n;
    logic [16:0]  a;

    always_comb
    begin
        n = s;
        a = s.acc + (tick ? 17'(FULL_W) : 17'h0);
        if (ld)
        begin
            // retarget from the present level, the fraction restarts
            n.tgt  = tgt;
            n.fade = fade;
            n.acc  = 17'h0;
        end
        else if (s.level == s.tgt)
        begin
            n.acc = 17'h0;
        end
        else if (s.fade == 16'h0)
        begin
            n.level = s.tgt;
        end
        else if (a >= {1'b0, s.fade})
        begin
            // 255 steps spread over fade ticks, at most one step per clock
            n.acc   = a - {1'b0, s.fade};
            n.level = (s.level < s.tgt) ? s.level + 8'h01
                                        : s.level - 8'h01;
        end
        else
        begin
            n.acc = a;
        end
        n.on = (n.level != 8'h00);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign level   = s.level;
    assign chan_on = s.on;

endmodule : dvs_ramp

/* design/dvs_ctrl.sv */
// dimmer channel: commands, limits, colour reduction and staircase light
`timescale 1ns/1ns
module dvs_ctrl #(
    parameter int TICK_CYC = dvs_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        we,
    input  wire logic        re,
    output logic      [31:0] rdata,
    // received telegrams, one-cycle strobes with their data
    input  wire logic        rel_stb,
    input  wire logic [3:0]  rel_code,
    input  wire logic        abs_stb,
    input  wire logic [7:0]  abs_val,
    input  wire logic        col_stb,
    input  wire logic [23:0] col_val,
    input  wire logic        trig_stb,
    input  wire logic        trig_val,
    input  wire logic        dn_stb,
    input  wire logic        dn_val,
    input  wire logic        lock,
    // channel state
    output logic      [7:0]  level,
    output logic             chan_on,
    output logic             day_mode,
    output logic      [1:0]  stair_state
);

    typedef struct packed {
        logic [dvs_pkg::NCFG-1:0][31:0] cfg;
        logic                           day;
        dvs_pkg::dvs_stair_t            st;
        logic [15:0]                    tmr;
        logic [9:0]                     ms;
        logic [dvs_pkg::PRE_W-1:0]      pre;
        logic                           tick;
        logic                           ld;
        logic [7:0]                     tgt;
        logic [15:0]                    fade;
        logic [31:0]                    rd;
    } dvs_ctrl_st_t;

    localparam logic [dvs_pkg::PRE_W-1:0] PRE_END =
        dvs_pkg::PRE_W'(TICK_CYC - 1);

    dvs_ctrl_st_t s;
    dvs_ctrl_st_t n;

    // configuration fields
    logic [31:0] ctrl;
    logic        stair_en;
    logic        zero_off;
    logic        on_hold;
    logic        retrig;
    logic [2:0]  col_sel;
    logic [2:0]  off_react;
    logic [3:0]  ori_code;
    logic [7:0]  lvl;

    // working values
    logic        sec;
    logic        go_on;
    logic        go_dly;
    logic        go_ori;
    logic        go_off;
    logic        cmd_ok;
    logic [8:0]  delta;
    logic [9:0]  sum;
    logic [9:0]  dif;
    logic [7:0]  v;
    logic [7:0]  cmin;
    logic [7:0]  cmax;

    assign ctrl      = s.cfg[dvs_pkg::A_CTRL];
    assign stair_en  = ctrl[dvs_pkg::C_STAIR];
    assign zero_off  = ctrl[dvs_pkg::C_ZOFF];
    assign on_hold   = ctrl[dvs_pkg::C_HOLD];
    assign retrig    = ctrl[dvs_pkg::C_RETRIG];
    assign col_sel   = ctrl[dvs_pkg::C_RGB +: 3];
    assign off_react = ctrl[dvs_pkg::C_OFFR +: 3];
    assign ori_code  = ctrl[dvs_pkg::C_ORI +: 4];

    // orientation light duration in seconds
    function automatic logic [15:0] ori_secs(input logic [3:0] c);
        case (c)
            4'h1:    ori_secs = 16'h0001;
            4'h2:    ori_secs = 16'h0002;
            4'h3:    ori_secs = 16'h0005;
            4'h4:    ori_secs = 16'h000a;
            4'h5:    ori_secs = 16'h001e;
            4'h6:    ori_secs = 16'h003c;
            4'h7:    ori_secs = 16'h0078;
            4'h8:    ori_secs = 16'h012c;
            4'h9:    ori_secs = 16'h0258;
            4'ha:    ori_secs = 16'h04b0;
            4'hb:    ori_secs = 16'h0708;
            4'hc:    ori_secs = 16'h0e10;
            4'hd:    ori_secs = 16'h1c20;
            default: ori_secs = 16'h0000;
        endcase
    endfunction : ori_secs

    function automatic logic [7:0] clamp(input logic [7:0] x,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
        if (x < lo)
            clamp = lo;
        else if (x > hi)
            clamp = hi;
        else
            clamp = x;
    endfunction : clamp

    // colour bytes: red is the first, most significant byte
    always_comb
    begin
        cmin = col_val[23:16];
        cmax = col_val[23:16];
        if (col_val[15:8] < cmin)
            cmin = col_val[15:8];
        if (col_val[7:0] < cmin)
            cmin = col_val[7:0];
        if (col_val[15:8] > cmax)
            cmax = col_val[15:8];
        if (col_val[7:0] > cmax)
            cmax = col_val[7:0];
    end

    always_comb
    begin
        n      = s;
        n.ld   = 1'b0;
        n.tick = 1'b0;
        sec    = 1'b0;
        go_on  = 1'b0;
        go_dly = 1'b0;
        go_ori = 1'b0;
        go_off = 1'b0;
        delta  = 9'h100 >> (rel_code[2:0] - 3'h1);
        sum    = {2'b00, lvl} + {1'b0, delta};
        dif    = {2'b00, lvl} - {1'b0, delta};
        v      = 8'h00;
        cmd_ok = !lock;

        // millisecond and second ticks
        if (s.pre == PRE_END)
        begin
            n.pre  = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.pre = s.pre + 1'b1;
        end
        if (s.tick)
        begin
            if (s.ms == dvs_pkg::MS_PER_S - 10'h001)
            begin
                n.ms = 10'h000;
                sec  = 1'b1;
            end
            else
            begin
                n.ms = s.ms + 10'h001;
            end
        end
        if (sec && s.tmr != 16'h0000)
            n.tmr = s.tmr - 16'h0001;

        // register port
        if (we && addr < dvs_pkg::NCFG)
            n.cfg[addr] = wdata;
        n.rd = 32'h00000000;
        if (re)
        begin
            if (addr < dvs_pkg::NCFG)
                n.rd = s.cfg[addr];
            else if (addr == dvs_pkg::A_STAT)
                n.rd = {20'h00000, s.st, s.day, chan_on, lvl};
        end

        if (dn_stb)
            n.day = dn_val;

        if (stair_en)
        begin
            if (trig_stb && cmd_ok)
            begin
                if (trig_val)
                begin
                    go_on = 1'b1;
                end
                else
                begin
                    unique case (dvs_pkg::dvs_offr_t'(off_react))
                        dvs_pkg::OFR_SWOFF:
                            go_off = 1'b1;
                        dvs_pkg::OFR_DELAY:
                            go_dly = (s.st == dvs_pkg::ST_ON) ||
                                     (s.st == dvs_pkg::ST_DELAY && retrig);
                        dvs_pkg::OFR_ORIENT:
                            go_ori = 1'b1;
                        dvs_pkg::OFR_TWOSTP:
                        begin
                            // a second OFF inside orientation ends it
                            go_ori = (s.st != dvs_pkg::ST_ORIENT);
                            go_off = (s.st == dvs_pkg::ST_ORIENT);
                        end
                        default:
                            go_off = 1'b0;
                    endcase
                end
            end
            else if (sec && s.tmr <= 16'h0001)
            begin
                if (s.st == dvs_pkg::ST_DELAY)
                begin
                    go_ori = (ori_code != dvs_pkg::ORI_DIS);
                    go_off = (ori_code == dvs_pkg::ORI_DIS);
                end
                else if (s.st == dvs_pkg::ST_ORIENT &&
                         ori_code != dvs_pkg::ORI_UNL)
                begin
                    go_off = 1'b1;
                end
            end

            if (go_on)
            begin
                n.ld   = 1'b1;
                n.tgt  = s.day ? s.cfg[dvs_pkg::A_SVAL][7:0]
                               : s.cfg[dvs_pkg::A_SVAL][15:8];
                n.fade = s.cfg[dvs_pkg::A_SFADE][15:0];
                if (on_hold)
                begin
                    n.st = dvs_pkg::ST_ON;
                end
                else
                begin
                    n.st = dvs_pkg::ST_DELAY;
                    if (s.st != dvs_pkg::ST_DELAY || retrig)
                        n.tmr = s.cfg[dvs_pkg::A_DLY][15:0];
                end
            end
            if (go_dly)
            begin
                n.st  = dvs_pkg::ST_DELAY;
                n.tmr = s.cfg[dvs_pkg::A_DLY][15:0];
            end
            if (go_ori)
            begin
                // with the duration disabled there is no orientation phase
                if (ori_code == dvs_pkg::ORI_DIS)
                begin
                    go_off = 1'b1;
                end
                else
                begin
                    n.st   = dvs_pkg::ST_ORIENT;
                    n.tmr  = ori_secs(ori_code);
                    n.ld   = 1'b1;
                    n.tgt  = s.cfg[dvs_pkg::A_OVAL][7:0];
                    n.fade = s.cfg[dvs_pkg::A_OFADE][15:0];
                end
            end
            if (go_off)
            begin
                n.st   = dvs_pkg::ST_OFF;
                n.ld   = 1'b1;
                n.tgt  = s.day ? s.cfg[dvs_pkg::A_SVAL][23:16]
                               : s.cfg[dvs_pkg::A_SVAL][31:24];
                n.fade = s.cfg[dvs_pkg::A_SFADE][31:16];
            end
        end
        else if (rel_stb && cmd_ok)
        begin
            n.ld = 1'b1;
            if (rel_code[2:0] == 3'h0)
            begin
                // stop code freezes the ramp where it stands
                n.tgt  = lvl;
                n.fade = s.cfg[dvs_pkg::A_RFADE][15:0];
            end
            else if (rel_code[3])
            begin
                n.fade = s.cfg[dvs_pkg::A_RFADE][15:0];
                if (lvl > s.cfg[dvs_pkg::A_RLIM][15:8])
                    n.tgt = lvl;
                else if (sum > {2'b00, s.cfg[dvs_pkg::A_RLIM][15:8]})
                    n.tgt = s.cfg[dvs_pkg::A_RLIM][15:8];
                else
                    n.tgt = sum[7:0];
            end
            else
            begin
                n.fade = s.cfg[dvs_pkg::A_RFADE][31:16];
                if (lvl < s.cfg[dvs_pkg::A_RLIM][7:0])
                    n.tgt = lvl;
                else if (dif[9] ||
                         dif < {2'b00, s.cfg[dvs_pkg::A_RLIM][7:0]})
                    n.tgt = s.cfg[dvs_pkg::A_RLIM][7:0];
                else
                    n.tgt = dif[7:0];
            end
        end
        else if (abs_stb && cmd_ok)
        begin
            n.ld = 1'b1;
            if (abs_val == 8'h00 && zero_off &&
                s.cfg[dvs_pkg::A_ALIM][7:0] != 8'h00)
                n.tgt = 8'h00;
            else
                n.tgt = clamp(abs_val, s.cfg[dvs_pkg::A_ALIM][7:0],
                              s.cfg[dvs_pkg::A_ALIM][15:8]);
            n.fade = (n.tgt >= lvl) ? s.cfg[dvs_pkg::A_AFADE][15:0]
                                    : s.cfg[dvs_pkg::A_AFADE][31:16];
        end
        else if (col_stb && cmd_ok)
        begin
            case (dvs_pkg::dvs_col_t'(col_sel))
                dvs_pkg::COL_GREEN:  v = col_val[15:8];
                dvs_pkg::COL_BLUE:   v = col_val[7:0];
                dvs_pkg::COL_WHITE:  v = cmin;
                dvs_pkg::COL_BRIGHT: v = cmax;
                default:             v = col_val[23:16];
            endcase
            n.ld   = 1'b1;
            n.tgt  = clamp(v, s.cfg[dvs_pkg::A_CLIM][7:0],
                           s.cfg[dvs_pkg::A_CLIM][15:8]);
            n.fade = (n.tgt >= lvl) ? s.cfg[dvs_pkg::A_CFADE][15:0]
                                    : s.cfg[dvs_pkg::A_CFADE][31:16];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s     <= '0;
            s.cfg <= dvs_pkg::CFG_RST;
            s.day <= 1'b1;
            s.st  <= dvs_pkg::ST_OFF;
        end
        else
        begin
            s <= n;
        end
    end

    // ramp runs one cycle behind the command decode
    dvs_ramp u_ramp (
        .clk     (clk),
        .rst     (rst),
        .tick    (s.tick),
        .ld      (s.ld),
        .tgt     (s.tgt),
        .fade    (s.fade),
        .level   (lvl),
        .chan_on (chan_on)
    );

    assign level       = lvl;
    assign rdata       = s.rd;
    assign day_mode    = s.day;
    assign stair_state = s.st;

endmodule : dvs_ctrl

/* tb/dvs_ctrl_asserts.sv */
// port-level assertions for the dimmer channel
`timescale 1ns/1ns
module dvs_ctrl_asserts #(
    parameter int TICK_CYC = dvs_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register port
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        we,
    input wire logic        re,
    input wire logic [31:0] rdata,
    // telegrams
    input wire logic        rel_stb,
    input wire logic [3:0]  rel_code,
    input wire logic        abs_stb,
    input wire logic [7:0]  abs_val,
    input wire logic        col_stb,
    input wire logic [23:0] col_val,
    input wire logic        trig_stb,
    input wire logic        trig_val,
    input wire logic        dn_stb,
    input wire logic        dn_val,
    input wire logic        lock,
    // channel state
    input wire logic [7:0]  level,
    input wire logic        chan_on,
    input wire logic        day_mode,
    input wire logic [1:0]  stair_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence stat_req;
        re && addr == dvs_pkg::A_STAT;
    endsequence

    chan_level_a: assert property (chan_on == (level != 8'h00))
        else $error("chan_on disagrees with level");
    rdata_idle_a: assert property (!$past(re) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    stat_read_a: assert property (stat_req |=> rdata == {20'h0,
        $past(stair_state), $past(day_mode), $past(chan_on), $past(level)})
        else $error("status word wrong");
    day_set_a: assert property (dn_stb |=> day_mode == $past(dn_val))
        else $error("day mode not taken");
    day_rst_a: assert property ($fell(rst) |-> day_mode &&
        level == 8'h00 && stair_state == 2'b00)
        else $error("state after restart wrong");
    // a locked trigger must not leave the idle state
    lock_trig_a: assert property (lock && trig_stb &&
        stair_state == 2'b00 |=> stair_state == 2'b00)
        else $error("locked trigger acted");
    off_stay_a: assert property (stair_state == 2'b00 &&
        !trig_stb |=> stair_state == 2'b00)
        else $error("idle left without trigger");
    delay_exit_a: assert property (stair_state == 2'b10 &&
        !trig_stb |=> stair_state inside {2'b10, 2'b11, 2'b00})
        else $error("delay left to wrong state");
    orient_exit_a: assert property (stair_state == 2'b11 &&
        !trig_stb |=> stair_state inside {2'b11, 2'b00})
        else $error("orientation left to wrong state");
endmodule : dvs_ctrl_asserts

bind dvs_ctrl dvs_ctrl_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
    .clk, .rst, .addr, .wdata, .we, .re, .rdata, .rel_stb, .rel_code,
    .abs_stb, .abs_val, .col_stb, .col_val, .trig_stb, .trig_val, .dn_stb,
    .dn_val, .lock, .level, .chan_on, .day_mode, .stair_state);

/* tb/dvs_bus_model.sv */
// bus-side model that delivers group telegrams to the dimmer channel
`timescale 1ns/1ns
module dvs_bus_model (
    // clock
    input  wire logic  clk,
    // telegrams towards the channel
    output logic        rel_stb,
    output logic [3:0]  rel_code,
    output logic        abs_stb,
    output logic [7:0]  abs_val,
    output logic        col_stb,
    output logic [23:0] col_val,
    output logic        trig_stb,
    output logic        trig_val,
    output logic        dn_stb,
    output logic        dn_val,
    output logic        lock
);
    logic [4:0]  stb_r;
    logic [23:0] d_r;

    initial
    begin
        stb_r = 5'h0;
        d_r   = 24'h0;
        lock  = 1'b0;
    end

    assign rel_stb  = stb_r[0];
    assign rel_code = d_r[3:0];
    assign abs_stb  = stb_r[1];
    assign abs_val  = d_r[7:0];
    assign col_stb  = stb_r[2];
    assign col_val  = d_r;
    assign trig_stb = stb_r[3];
    assign trig_val = d_r[0];
    assign dn_stb   = stb_r[4];
    assign dn_val   = d_r[0];

    // kind 0 rel, 1 abs, 2 colour, 3 trigger, 4 day/night
    task automatic send(input int k, input logic [23:0] d);
        @(posedge clk);
        stb_r <= 5'(1 << k);
        d_r   <= d;
        @(posedge clk);
        stb_r <= 5'h0;
        // stale data is not left on the lines after the telegram
        d_r   <= ~d;
    endtask : send

    task automatic set_lock(input logic v);
        @(posedge clk);
        lock <= v;
    endtask : set_lock
endmodule : dvs_bus_model

/* tb/dvs_ctrl_tb.sv */
// self-checking bench for the dimmer channel
`timescale 1ns/1ns
module dvs_ctrl_tb;
    logic        clk;
    logic        rst;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
    logic [31:0] rdata;
    logic        rel_stb;
    logic [3:0]  rel_code;
    logic        abs_stb;
    logic [7:0]  abs_val;
    logic        col_stb;
    logic [23:0] col_val;
    logic        trig_stb;
    logic        trig_val;
    logic        dn_stb;
    logic        dn_val;
    logic        lock;
    logic [7:0]  level;
    logic        chan_on;
    logic        day_mode;
    logic [1:0]  stair_state;
    int          err_total;
    int          samples_checked;
    logic [7:0]  exp_a [5] = '{8'he0, 8'h50, 8'h20, 8'h20, 8'he0};
    logic [7:0]  exp_b [5] = '{8'h30, 8'h5a, 8'h10, 8'h10, 8'h5a};

    dvs_bus_model u_bus (.clk, .rel_stb, .rel_code, .abs_stb, .abs_val,
        .col_stb, .col_val, .trig_stb, .trig_val, .dn_stb, .dn_val, .lock);

    // short tick keeps seconds at 4000 cycles
    dvs_ctrl #(.TICK_CYC(4)) u_dut (.clk, .rst, .addr, .wdata, .we, .re,
        .rdata, .rel_stb, .rel_code, .abs_stb, .abs_val, .col_stb, .col_val,
        .trig_stb, .trig_val, .dn_stb, .dn_val, .lock, .level, .chan_on,
        .day_mode, .stair_state);

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic stop_test;
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        we    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        we    <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        re   <= 1'b1;
        addr <= a;
        @(posedge clk);
        re   <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask : rd_chk

    // level settles by the third edge after the strobe with zero fade
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    task automatic cmd(input int k, input logic [23:0] d,
                       input logic [7:0] lv);
        u_bus.send(k, d);
        settle();
        chk("level", {24'h0, lv}, {24'h0, level});
        chk("chan_on", {31'h0, lv != 8'h00}, {31'h0, chan_on});
    endtask : cmd

    task automatic stair(input logic v, input logic [1:0] st,
                         input logic [7:0] lv);
        cmd(3, {23'h0, v}, lv);
        chk("stair_state", {30'h0, st}, {30'h0, stair_state});
    endtask : stair

    task automatic wait_st(input logic [1:0] st, input logic [7:0] lv);
        int n;
        n = 0;
        while (stair_state !== st && n < 12000)
        begin
            @(posedge clk);
            n++;
        end
        settle();
        chk("stair_state", {30'h0, st}, {30'h0, stair_state});
        chk("level", {24'h0, lv}, {24'h0, level});
    endtask : wait_st

    initial
    begin
        repeat (80000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial
    begin
        err_total = 0;
        samples_checked = 0;
        rst = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        we = 1'b0;
        re = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(dvs_pkg::A_STAT, 32'h00000200);
        rd_chk(dvs_pkg::A_CTRL, 32'h0);
        rd_chk(dvs_pkg::A_RLIM, dvs_pkg::LIM_RST);
        rd_chk(dvs_pkg::A_SVAL, dvs_pkg::SVAL_RST);
        rd_chk(dvs_pkg::A_OFADE, dvs_pkg::FADE_RST);
        rd_chk(4'hd, 32'h0);
        for (int i = 7; i < 12; i++)
            reg_wr(4'(i), 32'h0);
        reg_wr(dvs_pkg::A_ALIM, 32'h0000c020);
        cmd(1, 24'h10, 8'h20);
        cmd(1, 24'h00, 8'h20);
        reg_wr(dvs_pkg::A_CTRL, 32'h2);
        cmd(1, 24'h00, 8'h00);
        cmd(1, 24'hf0, 8'hc0);
        // slow brighter, instant darker
        reg_wr(dvs_pkg::A_AFADE, 32'h0000ffff);
        cmd(1, 24'h30, 8'h30);
        cmd(1, 24'h90, 8'h30);
        reg_wr(dvs_pkg::A_AFADE, 32'h0);
        reg_wr(dvs_pkg::A_ALIM, 32'h0000ff00);
        reg_wr(dvs_pkg::A_RLIM, 32'h00008040);
        cmd(1, 24'h30, 8'h30);
        cmd(0, 24'h1, 8'h30);
        cmd(1, 24'h90, 8'h90);
        cmd(0, 24'h9, 8'h90);
        cmd(0, 24'h1, 8'h40);
        reg_wr(dvs_pkg::A_CLIM, 32'h0000e010);
        for (int s = 0; s < 5; s++)
        begin
            reg_wr(dvs_pkg::A_CTRL, 32'(s) << 2);
            cmd(2, 24'hf05020, exp_a[s]);
            cmd(2, 24'h305a08, exp_b[s]);
        end
        u_bus.set_lock(1'b1);
        cmd(1, 24'h77, 8'h5a);
        u_bus.set_lock(1'b0);
        reg_wr(dvs_pkg::A_SVAL, 32'h000560c0);
        // two seconds keep a free-running second tick out of the checks
        reg_wr(dvs_pkg::A_DLY, 32'h2);
        reg_wr(dvs_pkg::A_CTRL, 32'h000000a1);
        stair(1'b1, 2'b01, 8'hc0);
        stair(1'b0, 2'b00, 8'h05);
        u_bus.send(4, 24'h0);
        settle();
        chk("day_mode", 32'h0, {31'h0, day_mode});
        stair(1'b1, 2'b01, 8'h60);
        stair(1'b0, 2'b00, 8'h00);
        u_bus.send(4, 24'h1);
        reg_wr(dvs_pkg::A_CTRL, 32'h00000401);
        stair(1'b1, 2'b10, 8'hc0);
        stair(1'b0, 2'b10, 8'hc0);
        wait_st(2'b11, 8'h1a);
        wait_st(2'b00, 8'h05);
        reg_wr(dvs_pkg::A_CTRL, 32'h00000121);
        stair(1'b1, 2'b01, 8'hc0);
        stair(1'b0, 2'b10, 8'hc0);
        wait_st(2'b00, 8'h05);
        reg_wr(dvs_pkg::A_CTRL, 32'h000039a1);
        stair(1'b1, 2'b01, 8'hc0);
        stair(1'b0, 2'b11, 8'h1a);
        reg_wr(dvs_pkg::A_CTRL, 32'h00003a21);
        stair(1'b1, 2'b01, 8'hc0);
        stair(1'b0, 2'b11, 8'h1a);
        stair(1'b0, 2'b00, 8'h05);
        reg_wr(dvs_pkg::A_DLY, 32'h3);
        reg_wr(dvs_pkg::A_CTRL, 32'h00000041);
        stair(1'b1, 2'b10, 8'hc0);
        repeat (8000) @(posedge clk);
        // second ON after two seconds must reload the delay
        stair(1'b1, 2'b10, 8'hc0);
        repeat (6000) @(posedge clk);
        chk("stair_state", 32'h2, {30'h0, stair_state});
        wait_st(2'b00, 8'h05);
        u_bus.set_lock(1'b1);
        stair(1'b1, 2'b00, 8'h05);
        u_bus.set_lock(1'b0);
        stop_test();
    end
endmodule : dvs_ctrl_tb
